// File: inc/ppb_cfg.svh
// Offsets, field masks, reset values and timing counts of the parallel port bank.
// Summary of operation
// - Ports 0, 1, 3 have eight-bit latch and direction, bit n drives pin n.
// - Port 1 latch and direction bits map one to one onto its eight pins.
// - Port 2 has latch, direction and upper-address enable, bit per pin.
// - Each upper-address enable bit gates one address line A16..A23 onto port 2.
// - An enabled address line owns its pin; latch and peripheral lose control.
// - Bus-control enable bits gate strobes, hold, ready and clock onto port 3.
// - An enabled bus-control pin belongs to the external bus function alone.
// - Port 3 latch and direction bits map one to one onto its pins.
// - Port 4 implements bits 4..0 only; bits 7..5 have no pin.
// - Port 5 has latch, direction and analog-enable registers, bit per pin.
// - Analog-enable bit n enables analog input on port 5 pin n.
// - Port 6 implements bits 3..0 only; upper four bits have no pin.
// - Latch drives output pins, reads return pin levels except on analog-enabled port 5 bits, direction per bit.
`ifndef PPB_CFG_SVH
`define PPB_CFG_SVH
`define PPB_REG_COUNT    17
`define PPB_OFS_LAT0     8'h00
`define PPB_OFS_DIR0     8'h04
`define PPB_OFS_LAT1     8'h08
`define PPB_OFS_DIR1     8'h0C
`define PPB_OFS_LAT2     8'h10
`define PPB_OFS_DIR2     8'h14
`define PPB_OFS_UAE      8'h18
`define PPB_OFS_LAT3     8'h1C
`define PPB_OFS_DIR3     8'h20
`define PPB_OFS_BCE      8'h24
`define PPB_OFS_LAT4     8'h28
`define PPB_OFS_DIR4     8'h2C
`define PPB_OFS_LAT5     8'h30
`define PPB_OFS_DIR5     8'h34
`define PPB_OFS_AIE      8'h38
`define PPB_OFS_LAT6     8'h3C
`define PPB_OFS_DIR6     8'h40
`define PPB_MASK_FULL    8'hFF
`define PPB_MASK_PORT4   8'h1F
`define PPB_MASK_PORT6   8'h0F
`define PPB_MASK_BCE     8'hFC
`define PPB_RST_LAT      8'h00
`define PPB_RST_DIR      8'h00
`define PPB_RST_UAE      8'h00
`define PPB_RST_BCE      8'h00
`define PPB_RST_AIE      8'h00
`define PPB_BCE_CLOCK    7
`define PPB_BCE_READY    6
`define PPB_WAIT_CYCLES  1
`endif

// File: inc/ppb_pkg.sv
// Types shared by the parallel port bank.
package ppb_pkg;
    typedef logic [4:0] ppb_idx_type;
    typedef logic [7:0] ppb_byte_type;
    typedef struct packed {
        logic [16:0][7:0] regs;
        logic             ack;
        logic [31:0]      rdata;
    } ppb_state_type;
endpackage

// File: rtl/ppb_top.sv
// Parallel port bank with pin overrides behind an Avalon-MM slave.
`timescale 1ns/10ps
`include "ppb_cfg.svh"
module ppb_top (
    // Clock and reset.
    input  wire logic        sys_clk_i,
    input  wire logic        srst_i,
    // Avalon-MM slave.
    input  wire logic [7:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    // Port 0 pins.
    input  wire logic [7:0]  p0_pin_i,
    output logic      [7:0]  p0_pin_o,
    output logic      [7:0]  p0_pin_oe_o,
    // Port 1 pins.
    input  wire logic [7:0]  p1_pin_i,
    output logic      [7:0]  p1_pin_o,
    output logic      [7:0]  p1_pin_oe_o,
    // Port 2 pins.
    input  wire logic [7:0]  p2_pin_i,
    output logic      [7:0]  p2_pin_o,
    output logic      [7:0]  p2_pin_oe_o,
    // Port 3 pins.
    input  wire logic [7:0]  p3_pin_i,
    output logic      [7:0]  p3_pin_o,
    output logic      [7:0]  p3_pin_oe_o,
    // Port 4 pins.
    input  wire logic [4:0]  p4_pin_i,
    output logic      [4:0]  p4_pin_o,
    output logic      [4:0]  p4_pin_oe_o,
    // Port 5 pins.
    input  wire logic [7:0]  p5_pin_i,
    output logic      [7:0]  p5_pin_o,
    output logic      [7:0]  p5_pin_oe_o,
    // Port 6 pins.
    input  wire logic [3:0]  p6_pin_i,
    output logic      [3:0]  p6_pin_o,
    output logic      [3:0]  p6_pin_oe_o,
    // External bus function.
    input  wire logic [7:0]  ext_addr_i,
    input  wire logic [7:0]  bus_ctl_out_i,
    input  wire logic [7:0]  bus_ctl_oe_i,
    // Pin ownership towards peripherals and the converter.
    output logic      [7:0]  p2_periph_en_o,
    output logic      [7:0]  p3_periph_en_o,
    output logic      [7:0]  analog_en_o
);

    // Register indices in the state array.
    localparam ppb_pkg::ppb_idx_type IDX_UAE = 5'd6;
    localparam ppb_pkg::ppb_idx_type IDX_BCE = 5'd9;
    localparam ppb_pkg::ppb_idx_type IDX_AIE = 5'd14;

    ppb_pkg::ppb_state_type state_q;
    ppb_pkg::ppb_state_type state_d;
    logic [6:0][7:0]        pin_in;
    logic [6:0][7:0]        lat;
    logic [6:0][7:0]        dir;
    logic [7:0]             uae;
    logic [7:0]             bce;
    logic [7:0]             aie;
    logic                   req;
    logic                   hit;
    logic [5:0]             dec;
    ppb_pkg::ppb_idx_type   idx;

    // Maps a byte address to a register index; bit 5 flags a mapped address.
    function automatic logic [5:0] decode(input logic [7:0] addr);
        case (addr)
            `PPB_OFS_LAT0: decode = {1'b1, 5'd0};
            `PPB_OFS_DIR0: decode = {1'b1, 5'd1};
            `PPB_OFS_LAT1: decode = {1'b1, 5'd2};
            `PPB_OFS_DIR1: decode = {1'b1, 5'd3};
            `PPB_OFS_LAT2: decode = {1'b1, 5'd4};
            `PPB_OFS_DIR2: decode = {1'b1, 5'd5};
            `PPB_OFS_UAE:  decode = {1'b1, 5'd6};
            `PPB_OFS_LAT3: decode = {1'b1, 5'd7};
            `PPB_OFS_DIR3: decode = {1'b1, 5'd8};
            `PPB_OFS_BCE:  decode = {1'b1, 5'd9};
            `PPB_OFS_LAT4: decode = {1'b1, 5'd10};
            `PPB_OFS_DIR4: decode = {1'b1, 5'd11};
            `PPB_OFS_LAT5: decode = {1'b1, 5'd12};
            `PPB_OFS_DIR5: decode = {1'b1, 5'd13};
            `PPB_OFS_AIE:  decode = {1'b1, 5'd14};
            `PPB_OFS_LAT6: decode = {1'b1, 5'd15};
            `PPB_OFS_DIR6: decode = {1'b1, 5'd16};
            default:       decode = 6'h00;
        endcase
    endfunction

    // Writable bits of each register; pinless and unused bits stay zero.
    function automatic logic [7:0] wmask(input ppb_pkg::ppb_idx_type i);
        case (i)
            5'd9:         wmask = `PPB_MASK_BCE;
            5'd10, 5'd11: wmask = `PPB_MASK_PORT4;
            5'd15, 5'd16: wmask = `PPB_MASK_PORT6;
            default:      wmask = `PPB_MASK_FULL;
        endcase
    endfunction

    // Reset value of each register.
    function automatic logic [7:0] rstval(input ppb_pkg::ppb_idx_type i);
        case (i)
            5'd6:    rstval = `PPB_RST_UAE;
            5'd9:    rstval = `PPB_RST_BCE;
            5'd14:   rstval = `PPB_RST_AIE;
            5'd1, 5'd3, 5'd5, 5'd8, 5'd11, 5'd13, 5'd16: rstval = `PPB_RST_DIR;
            default: rstval = `PPB_RST_LAT;
        endcase
    endfunction

    // Address decode and the request seen by the slave.
    assign req = avs_read_i | avs_write_i;
    assign dec = decode(avs_address_i);
    assign hit = dec[5];
    assign idx = dec[4:0];

    // Pin levels widened to eight bits per port.
    assign pin_in[0] = p0_pin_i;
    assign pin_in[1] = p1_pin_i;
    assign pin_in[2] = p2_pin_i;
    assign pin_in[3] = p3_pin_i;
    assign pin_in[4] = {3'b000, p4_pin_i};
    assign pin_in[5] = p5_pin_i;
    assign pin_in[6] = {4'h0, p6_pin_i};

    // Latch and direction views; port 3 and onward skip the override slots.
    assign lat[0] = state_q.regs[0];
    assign dir[0] = state_q.regs[1];
    assign lat[1] = state_q.regs[2];
    assign dir[1] = state_q.regs[3];
    assign lat[2] = state_q.regs[4];
    assign dir[2] = state_q.regs[5];
    assign lat[3] = state_q.regs[7];
    assign dir[3] = state_q.regs[8];
    assign lat[4] = state_q.regs[10];
    assign dir[4] = state_q.regs[11];
    assign lat[5] = state_q.regs[12];
    assign dir[5] = state_q.regs[13];
    assign lat[6] = state_q.regs[15];
    assign dir[6] = state_q.regs[16];
    assign uae    = state_q.regs[IDX_UAE];
    assign bce    = state_q.regs[IDX_BCE];
    assign aie    = state_q.regs[IDX_AIE];

    // Next state: one wait cycle, then the write lands and read data stand.
    // The acknowledge toggles, so a held request is taken every second cycle, and a
    // write lands on the edge at which waitrequest is seen low.
    // Pin levels are sampled in the wait cycle, so a read shows the board as
    // it stood one cycle before the answer.
    always_comb begin
        logic [7:0] rd;
        rd      = 8'h00;
        state_d = state_q;
        state_d.ack = req & ~state_q.ack;
        if (req && !state_q.ack) begin
            if (hit && avs_read_i) begin
                rd = state_q.regs[idx];
                case (idx)
                    5'd0:  rd = pin_in[0];
                    5'd2:  rd = pin_in[1];
                    5'd4:  rd = pin_in[2];
                    5'd7:  rd = pin_in[3];
                    5'd10: rd = pin_in[4] & `PPB_MASK_PORT4;
                    5'd12: rd = pin_in[5] & ~aie;
                    5'd15: rd = pin_in[6] & `PPB_MASK_PORT6;
                    default: rd = state_q.regs[idx];
                endcase
            end
            state_d.rdata = {24'h00_0000, rd};
        end
        if (state_q.ack && avs_write_i && hit && avs_byteenable_i[0]) begin
            for (int i = 0; i < `PPB_REG_COUNT; i++) begin
                if (idx == i[4:0]) begin
                    state_d.regs[i] = avs_writedata_i[7:0] & wmask(i[4:0]);
                end
            end
        end
        if (srst_i) begin
            for (int i = 0; i < `PPB_REG_COUNT; i++) begin
                state_d.regs[i] = rstval(i[4:0]);
            end
            state_d.ack   = 1'b0;
            state_d.rdata = 32'h0000_0000;
        end
    end

    // State register.
    always_ff @(posedge sys_clk_i) begin
        state_q <= state_d;
    end

    // Bus answers.
    assign avs_waitrequest_o = req & ~state_q.ack;
    assign avs_readdata_o    = state_q.rdata;

    // Plain ports: latch out, direction one drives.
    assign p0_pin_o    = lat[0];
    assign p0_pin_oe_o = dir[0];
    assign p1_pin_o    = lat[1];
    assign p1_pin_oe_o = dir[1];
    assign p5_pin_o    = lat[5];
    assign p5_pin_oe_o = dir[5];
    assign p4_pin_o    = lat[4][4:0];
    assign p4_pin_oe_o = dir[4][4:0];
    assign p6_pin_o    = lat[6][3:0];
    assign p6_pin_oe_o = dir[6][3:0];

    // Per-bit overrides of ports 2 and 3.
    // An enabled address line drives its pin whatever the direction bit says,
    // while a bus-control pin takes its drive enable from the bus function.
    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_ovr
            assign p2_pin_o[g]    = uae[g] ? ext_addr_i[g] : lat[2][g];
            assign p2_pin_oe_o[g] = uae[g] | dir[2][g];
            assign p3_pin_o[g]    = bce[g] ? bus_ctl_out_i[g] : lat[3][g];
            assign p3_pin_oe_o[g] = bce[g] ? bus_ctl_oe_i[g] : dir[3][g];
        end
    endgenerate

    // Ownership flags for the shared functions.
    assign p2_periph_en_o = ~uae;
    assign p3_periph_en_o = ~bce;
    assign analog_en_o    = aie;

    // Helpers: a write that lands and a read that is taken, for the checks below.
    logic wr_done;
    logic rd_go;
    assign wr_done = avs_write_i & state_q.ack & hit & avs_byteenable_i[0];
    assign rd_go   = avs_read_i & ~state_q.ack & hit;

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (srst_i);

    // Checks on the bus timing and the pin logic.
    wait_one_a: assert property (req && !state_q.ack |=> !avs_waitrequest_o)
        else $error("waitrequest not released after one cycle");
    wr_lands_a: assert property (wr_done && idx == 5'd1
        |=> p0_pin_oe_o == $past(avs_writedata_i[7:0]))
        else $error("direction write did not reach port 0");
    dir_reset_a: assert property (disable iff (1'b0)
        srst_i |=> p0_pin_oe_o == 8'h00 && p3_pin_oe_o == 8'h00)
        else $error("direction not cleared by reset");
    addr_own_a: assert property (uae[0] |-> p2_pin_o[0] == ext_addr_i[0] && p2_pin_oe_o[0])
        else $error("address line lost port 2 pin");
    bus_own_a: assert property (bce[7] |-> p3_pin_oe_o[7] == bus_ctl_oe_i[7])
        else $error("bus control lost port 3 pin");
    p4_upper_a: assert property (wr_done && idx == 5'd10 |=> lat[4][7:5] == 3'b000)
        else $error("port 4 pinless bits took a write");
    p6_read_a: assert property (rd_go && idx == 5'd15
        |=> avs_readdata_o[7:4] == 4'h0)
        else $error("port 6 pinless bits read nonzero");
    analog_rd_a: assert property (rd_go && idx == 5'd12
        |=> (avs_readdata_o[7:0] & $past(aie)) == 8'h00)
        else $error("analog pin read as digital");
    pin_rd_a: assert property (rd_go && idx == 5'd2
        |=> avs_readdata_o[7:0] == $past(p1_pin_i))
        else $error("port 1 read did not return pins");

    // Bus handshake: one wait cycle, read data stand until the next request.
    wait_first_a: assert property (req && !state_q.ack
        |-> avs_waitrequest_o)
        else $error("request answered without a wait cycle");
    ack_idle_a: assert property (!req
        |=> !state_q.ack)
        else $error("acknowledge without a request");
    rdata_stand_a: assert property (!(req && !state_q.ack)
        |=> $stable(avs_readdata_o))
        else $error("read data changed without a request");
    hi_zero_a: assert property (rd_go
        |=> avs_readdata_o[31:8] == 24'h00_0000)
        else $error("upper read data bits not zero");
    unmapped_rd_a: assert property (avs_read_i && !state_q.ack && !hit
        |=> avs_readdata_o == 32'h0000_0000)
        else $error("unmapped read returned data");
    be_off_a: assert property (avs_write_i && state_q.ack && !avs_byteenable_i[0]
        |=> $stable(state_q.regs))
        else $error("write without byte enable changed a register");

    // Register writes reach the pins, ownership outputs or register bits of the matching port.
    lat0_lands_a: assert property (wr_done && idx == 5'd0
        |=> p0_pin_o == $past(avs_writedata_i[7:0]))
        else $error("latch write did not reach port 0");
    lat1_lands_a: assert property (wr_done && idx == 5'd2
        |=> p1_pin_o == $past(avs_writedata_i[7:0]))
        else $error("latch write did not reach port 1");
    dir1_lands_a: assert property (wr_done && idx == 5'd3
        |=> p1_pin_oe_o == $past(avs_writedata_i[7:0]))
        else $error("direction write did not reach port 1");
    lat2_lands_a: assert property (wr_done && idx == 5'd4 && uae == 8'h00
        |=> p2_pin_o == $past(avs_writedata_i[7:0]))
        else $error("latch write did not reach port 2");
    dir2_lands_a: assert property (wr_done && idx == 5'd5 && uae == 8'h00
        |=> p2_pin_oe_o == $past(avs_writedata_i[7:0]))
        else $error("direction write did not reach port 2");
    uae_lands_a: assert property (wr_done && idx == 5'd6
        |=> p2_periph_en_o == ~$past(avs_writedata_i[7:0]))
        else $error("address enable write did not take effect");
    lat3_lands_a: assert property (wr_done && idx == 5'd7 && bce == 8'h00
        |=> p3_pin_o == $past(avs_writedata_i[7:0]))
        else $error("latch write did not reach port 3");
    dir3_lands_a: assert property (wr_done && idx == 5'd8 && bce == 8'h00
        |=> p3_pin_oe_o == $past(avs_writedata_i[7:0]))
        else $error("direction write did not reach port 3");
    bce_lands_a: assert property (wr_done && idx == 5'd9
        |=> p3_periph_en_o == ~($past(avs_writedata_i[7:0]) & `PPB_MASK_BCE))
        else $error("bus control enable write did not take effect");
    lat4_lands_a: assert property (wr_done && idx == 5'd10
        |=> p4_pin_o == $past(avs_writedata_i[4:0]))
        else $error("latch write did not reach port 4");
    dir4_lands_a: assert property (wr_done && idx == 5'd11
        |=> p4_pin_oe_o == $past(avs_writedata_i[4:0]))
        else $error("direction write did not reach port 4");
    lat5_lands_a: assert property (wr_done && idx == 5'd12
        |=> p5_pin_o == $past(avs_writedata_i[7:0]))
        else $error("latch write did not reach port 5");
    dir5_lands_a: assert property (wr_done && idx == 5'd13
        |=> p5_pin_oe_o == $past(avs_writedata_i[7:0]))
        else $error("direction write did not reach port 5");
    aie_lands_a: assert property (wr_done && idx == 5'd14
        |=> analog_en_o == $past(avs_writedata_i[7:0]))
        else $error("analog enable write did not take effect");
    lat6_lands_a: assert property (wr_done && idx == 5'd15
        |=> p6_pin_o == $past(avs_writedata_i[3:0]))
        else $error("latch write did not reach port 6");
    dir6_lands_a: assert property (wr_done && idx == 5'd16
        |=> p6_pin_oe_o == $past(avs_writedata_i[3:0]))
        else $error("direction write did not reach port 6");
    p6_dir_hi_a: assert property (wr_done && idx == 5'd16
        |=> dir[6][7:4] == 4'h0)
        else $error("port 6 pinless direction bits took a write");
    p4_dir_hi_a: assert property (wr_done && idx == 5'd11
        |=> dir[4][7:5] == 3'b000)
        else $error("port 4 pinless direction bits took a write");

    // Pin ownership of the overridden ports.
    addr_hi_own_a: assert property (uae[7]
        |-> p2_pin_o[7] == ext_addr_i[7] && p2_pin_oe_o[7])
        else $error("top address line lost its pin");
    bus_val_a: assert property (bce[6]
        |-> p3_pin_o[6] == bus_ctl_out_i[6])
        else $error("ready pin not given to the bus function");
    gpio_p3_a: assert property (!bce[2]
        |-> p3_pin_o[2] == lat[3][2] && p3_pin_oe_o[2] == dir[3][2])
        else $error("port 3 pin not under port control");
    bce_low_a: assert property (1'b1
        |-> bce[1:0] == 2'b00)
        else $error("unused bus control enable bits set");

    // Reads return the pins of data ports and the registers otherwise.
    p0_pin_rd_a: assert property (rd_go && idx == 5'd0
        |=> avs_readdata_o[7:0] == $past(p0_pin_i))
        else $error("port 0 read did not return pins");
    p3_pin_rd_a: assert property (rd_go && idx == 5'd7
        |=> avs_readdata_o[7:0] == $past(p3_pin_i))
        else $error("port 3 read did not return pins");
    dir_rd_a: assert property (rd_go && idx == 5'd1
        |=> avs_readdata_o[7:0] == $past(dir[0]))
        else $error("direction read did not return the register");

    // Main scenarios.
    wr_cov_c:  cover property (wr_done && idx == IDX_UAE ##1 uae != 8'h00);
    rd_cov_c:  cover property (avs_read_i && !avs_waitrequest_o && hit);
    bce_cov_c: cover property (bce[`PPB_BCE_READY] && p3_periph_en_o[`PPB_BCE_CLOCK] == 1'b0);
    aie_cov_c: cover property (analog_en_o == 8'hFF);
    p5_rd_c:   cover property (rd_go && idx == 5'd12 && analog_en_o != 8'h00);

endmodule

// File: sim/ppb_top_bench.sv
// Self-checking bench for the parallel port bank with pin overrides.
`timescale 1ns/10ps
`include "ppb_cfg.svh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin $display("[ERR] %0t got %h exp %h", $time, a, b); err_count++; end end
module ppb_top_bench;
    logic        sys_clk_i = 1'b0;
    logic        srst_i = 1'b1;
    logic [7:0]  avs_address_i = 8'h00;
    logic        avs_read_i = 1'b0;
    logic        avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0000_0000;
    logic [3:0]  avs_byteenable_i = 4'h0;
    logic [31:0] avs_readdata_o;
    logic        avs_waitrequest_o;
    logic [7:0]  ext_q = 8'h3C;
    logic [7:0]  ext_addr_i = 8'h00;
    logic [7:0]  bus_ctl_out_i = 8'h00;
    logic [7:0]  bus_ctl_oe_i = 8'h00;
    logic [7:0]  p0_pin_o, p0_pin_oe_o, p1_pin_o, p1_pin_oe_o, p2_pin_o, p2_pin_oe_o;
    logic [7:0]  p3_pin_o, p3_pin_oe_o, p5_pin_o, p5_pin_oe_o;
    logic [4:0]  p4_pin_o, p4_pin_oe_o;
    logic [3:0]  p6_pin_o, p6_pin_oe_o;
    logic [7:0]  p2_periph_en_o, p3_periph_en_o, analog_en_o;
    logic [7:0]  po [7];
    logic [7:0]  pe [7];
    logic [7:0]  pw [7];
    int          err_count = 0;
    int          n_checks = 0;
    int          cyc = 0;
    logic [7:0]  lat_ofs [7] = '{8'h00, 8'h08, 8'h10, 8'h1C, 8'h28, 8'h30, 8'h3C};
    logic [7:0]  msk [7] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h1F, 8'hFF, 8'h0F};

    // Clock of 10 ns period.
    initial begin
        forever #5 sys_clk_i = ~sys_clk_i;
    end

    // Pin level: the driven value where enabled, otherwise the board level.
    assign po = '{p0_pin_o, p1_pin_o, p2_pin_o, p3_pin_o, {3'b000, p4_pin_o}, p5_pin_o,
                  {4'h0, p6_pin_o}};
    assign pe = '{p0_pin_oe_o, p1_pin_oe_o, p2_pin_oe_o, p3_pin_oe_o, {3'b000, p4_pin_oe_o},
                  p5_pin_oe_o, {4'h0, p6_pin_oe_o}};
    for (genvar k = 0; k < 7; k++) begin : g_pin
        assign pw[k] = (po[k] & pe[k]) | (ext_q & ~pe[k]);
    end

    ppb_top DUT (
        .sys_clk_i(sys_clk_i), .srst_i(srst_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .p0_pin_i(pw[0]), .p0_pin_o(p0_pin_o),
        .p0_pin_oe_o(p0_pin_oe_o), .p1_pin_i(pw[1]), .p1_pin_o(p1_pin_o),
        .p1_pin_oe_o(p1_pin_oe_o), .p2_pin_i(pw[2]), .p2_pin_o(p2_pin_o),
        .p2_pin_oe_o(p2_pin_oe_o), .p3_pin_i(pw[3]), .p3_pin_o(p3_pin_o),
        .p3_pin_oe_o(p3_pin_oe_o), .p4_pin_i(pw[4][4:0]), .p4_pin_o(p4_pin_o),
        .p4_pin_oe_o(p4_pin_oe_o), .p5_pin_i(pw[5]), .p5_pin_o(p5_pin_o),
        .p5_pin_oe_o(p5_pin_oe_o), .p6_pin_i(pw[6][3:0]), .p6_pin_o(p6_pin_o),
        .p6_pin_oe_o(p6_pin_oe_o), .ext_addr_i(ext_addr_i), .bus_ctl_out_i(bus_ctl_out_i),
        .bus_ctl_oe_i(bus_ctl_oe_i), .p2_periph_en_o(p2_periph_en_o),
        .p3_periph_en_o(p3_periph_en_o), .analog_en_o(analog_en_o)
    );

    // One bus cycle; the request stands until waitrequest is seen low at a rising edge.
    // One idle edge follows, so the pins show the landed write when the task returns.
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
                       input logic [3:0] be, output logic [31:0] q);
        @(posedge sys_clk_i);
        avs_read_i <= ~w;
        avs_write_i <= w;
        avs_address_i <= a;
        avs_writedata_i <= {24'h00_0000, d};
        avs_byteenable_i <= be;
        do begin
            @(posedge sys_clk_i);
        end while (avs_waitrequest_o !== 1'b0);
        q = avs_readdata_o;
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
        @(posedge sys_clk_i);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, 4'h1, q);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        logic [31:0] q;
        bus(1'b0, a, 8'h00, 4'hF, q);
        `CHK(q, {24'h00_0000, e});
    endtask

    // Reset state of enables, directions and ownership outputs.
    task automatic t_reset;
        for (int p = 0; p < 7; p++) begin
            `CHK(pe[p], 8'h00);
            rd_chk(lat_ofs[p] + 8'h04, 8'h00);
        end
        `CHK(p2_periph_en_o, 8'hFF);
        `CHK(analog_en_o, 8'h00);
        rd_chk(`PPB_OFS_UAE, 8'h00);
    endtask

    // Latch and direction map bit for bit onto each port's pins.
    task automatic t_ports;
        for (int p = 0; p < 7; p++) begin
            wr(lat_ofs[p], 8'hA5);
            wr(lat_ofs[p] + 8'h04, 8'hFF);
            rd_chk(lat_ofs[p] + 8'h04, msk[p]);
            `CHK(po[p], 8'hA5 & msk[p]);
            `CHK(pe[p], msk[p]);
            wr(lat_ofs[p] + 8'h04, 8'h0F);
            `CHK(pe[p], 8'h0F & msk[p]);
            rd_chk(lat_ofs[p], 8'h35 & msk[p]);
            wr(lat_ofs[p] + 8'h04, 8'h00);
        end
    endtask

    // Upper address lines take over the enabled port 2 pins.
    task automatic t_port2;
        ext_addr_i <= 8'hA5;
        wr(`PPB_OFS_UAE, 8'h81);
        wr(`PPB_OFS_LAT2, 8'h00);
        wr(`PPB_OFS_DIR2, 8'hFF);
        `CHK(p2_pin_o, 8'h81);
        `CHK(p2_periph_en_o, 8'h7E);
        wr(`PPB_OFS_DIR2, 8'h00);
        `CHK(p2_pin_oe_o, 8'h81);
        wr(`PPB_OFS_UAE, 8'h00);
        `CHK(p2_pin_oe_o, 8'h00);
    endtask

    // Bus control signals take over the enabled port 3 pins.
    task automatic t_port3;
        bus_ctl_out_i <= 8'hC3;
        bus_ctl_oe_i <= 8'h40;
        wr(`PPB_OFS_LAT3, 8'hFF);
        wr(`PPB_OFS_BCE, 8'hFF);
        rd_chk(`PPB_OFS_BCE, 8'hFC);
        `CHK(p3_periph_en_o, 8'h03);
        `CHK(p3_pin_o, 8'hC3);
        `CHK(p3_pin_oe_o, 8'h40);
        wr(`PPB_OFS_BCE, 8'h00);
        `CHK(p3_pin_oe_o, 8'h00);
    endtask

    // Analog enables and refused accesses.
    task automatic t_misc;
        logic [31:0] q;
        wr(`PPB_OFS_AIE, 8'h0F);
        `CHK(analog_en_o, 8'h0F);
        rd_chk(`PPB_OFS_LAT5, 8'h30);
        bus(1'b1, `PPB_OFS_DIR0, 8'hFF, 4'h0, q);
        rd_chk(`PPB_OFS_DIR0, 8'h00);
        wr(8'h44, 8'hFF);
        rd_chk(8'h44, 8'h00);
    endtask

    // A reset in mid-run clears the directions again.
    task automatic t_rerst;
        wr(`PPB_OFS_DIR0, 8'hFF);
        `CHK(p0_pin_oe_o, 8'hFF);
        srst_i <= 1'b1;
        repeat (2) @(posedge sys_clk_i);
        srst_i <= 1'b0;
        @(posedge sys_clk_i);
        `CHK(p0_pin_oe_o, 8'h00);
        rd_chk(`PPB_OFS_DIR0, 8'h00);
    endtask

    // Cuts a hang short.
    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            summarize();
        end
    end

    task automatic summarize;
        if (err_count == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Main sequence.
    initial begin
        repeat (10) @(posedge sys_clk_i);
        srst_i <= 1'b0;
        t_reset();
        t_ports();
        t_port2();
        t_port3();
        t_misc();
        t_rerst();
        summarize();
    end
endmodule
